// >>> design/mcid_decoder.sv
// What this block does
// - leading word bit picks short or long layout
// - bit 8 picks first operand bank
// - bit 14 picks second operand bank
// - store bit routes result: register or memory
// - branch on condition match, mismatch or always
// - opcode 1 decodes absolute branches
// - opcodes 10, 11 short: relative branches
// - opcode 14 long, store-bit one: subroutine call
// - opcode 10 long, bit zero: double add
// - opcode 12 bit zero: character exchange or load
// - opcode 12 bit one: character store
// - opcode 13 bit one: character compare
// - opcode 13 word compare forms
// - opcode 4 bit one: clear memory
// - opcode 7 short: single shifts, selector
// - opcode 7 short: double shifts, same selector
// - opcodes 14, 15 short: table moves
// - opcodes 14, 15 short: privileged external register
// - opcode 8: floating load or store
// - opcode 7 memory forms: segment table
// - unmatched encodings raise the trap
// - floating load, store and arithmetic classes trap without the option
// - mode field decodes addressing type
module mcid_decoder
  import mcid_pkg::*;
(
  input  wire logic        REF_CLK,
  input  wire logic        SRST,
  input  wire logic        LOAD_WORD,
  input  wire logic [15:0] INSTR_IN,
  input  wire logic [1:0]  CONDITION_REGISTER,
  input  wire logic        FLOATING_POINT_OPTION,
  output mcid_op_t         OP_CLASS,
  output logic             TRAP_REQUEST,
  output logic             PRIVILEGED,
  output logic [3:0]       OPERATION_CODE_FIELD,
  output logic [3:0]       FIRST_OPERAND_SELECT,
  output logic [3:0]       SECOND_OPERAND_SELECT,
  output logic [2:0]       SHORT_FORMAT_REGISTER,
  output logic [2:0]       BRANCH_CONDITION_FIELD,
  output logic [1:0]       ADDRESSING_MODE_FIELD,
  output mcid_addr_t       ADDRESS_TYPE,
  output logic             STORE_TO_MEMORY,
  output logic             BRANCH_TAKEN,
  output mcid_shift_t      SHIFT_KIND,
  output logic             SHIFT_RIGHT
);

  // ---------------------------------------------------------
  // captured word and field extraction
  // ---------------------------------------------------------
  logic [15:0]  word;
  mcid_fields_if f ();
  mcid_op_t     next_class;
  logic         next_priv;
  logic         mem_type;
  logic         short_fmt;

  // only the captured word is state; reset clears it
  always_ff @(posedge REF_CLK) begin
    if (SRST) begin
      word <= WORD_RESET;
    end else if (LOAD_WORD) begin
      word <= INSTR_IN;
    end
  end

  assign f.word = word;

  mcid_field_extract u_extract (
    .f (f)
  );

  // layout choice and memory-addressed types
  assign short_fmt = !f.fmt;
  assign mem_type  = f.fmt && f.mode[1];

  // ---------------------------------------------------------
  // operation class decode
  // ---------------------------------------------------------
  // a single case keeps every word on exactly one class, so
  // the sequencer never sees two operations at once
  always_comb begin
    next_class = OP_TRAP;
    next_priv  = 1'b0;
    case (f.opcode)
      CODE_LOAD, CODE_ADD, CODE_SUB, CODE_OR, CODE_XOR: begin
        next_class = OP_GENERAL;
      end
      CODE_ABS: begin
        if (short_fmt) begin
          next_class = OP_ABS_COND;
        end else if (mem_type) begin
          next_class = f.ls ? OP_TRAP : OP_ABS;
        end else if (f.addr_type == AT_T2 && f.ls) begin
          next_class = OP_TRAP;
        end else begin
          next_class = OP_ABS_COND;
        end
      end
      CODE_AND: begin
        if (short_fmt || !f.ls || f.addr_type == AT_T1) begin
          next_class = OP_GENERAL;
        end else if (f.addr_type != AT_T2) begin
          next_class = OP_CLEAR_MEM;
        end
      end
      CODE_SHIFT: begin
        if (short_fmt) begin
          // the register field tells single from double
          if (f.short_reg != 3'h0) begin
            next_class = OP_SHIFT1;
          end else begin
            next_class = OP_SHIFT2;
          end
          if (SHIFT_KIND == SH_NORM && f.ls) begin
            next_class = OP_TRAP;
          end
        end else if (f.addr_type == AT_T1) begin
          next_class = OP_TRAP;
        end else if (f.addr_type == AT_T2) begin
          next_class = f.ls ? OP_TRAP : OP_GENERAL;
        end else if (f.first_sel == 4'h0) begin
          next_class = f.ls ? OP_SEG_STORE : OP_SEG_LOAD;
          next_priv  = 1'b1;
        end else begin
          next_class = OP_GENERAL;
        end
      end
      CODE_FPLS: begin
        if (short_fmt || f.addr_type == AT_T1) begin
          next_class = OP_GENERAL;
        end else if (f.addr_type == AT_T2) begin
          next_class = f.ls ? OP_TRAP : OP_GENERAL;
        end else begin
          next_class = f.ls ? OP_FP_STORE : OP_FP_LOAD;
        end
      end
      CODE_FPAR: begin
        next_class = short_fmt ? OP_GENERAL : OP_FP_ARITH;
      end
      CODE_FWD: begin
        if (short_fmt) begin
          next_class = f.ls ? OP_TRAP : OP_REL_FWD;
        end else if (!f.ls) begin
          next_class = OP_DADD;
        end else if (f.addr_type != AT_T1 && f.addr_type != AT_T2) begin
          next_class = OP_GENERAL;
          next_priv  = 1'b1;
        end
      end
      CODE_BWD: begin
        if (short_fmt) begin
          next_class = f.ls ? OP_TRAP : OP_REL_BWD;
        end else if (!f.ls) begin
          next_class = OP_GENERAL;
        end
      end
      CODE_CHAR: begin
        if (short_fmt) begin
          next_class = OP_TRAP;
        end else if (!f.ls) begin
          if (f.addr_type == AT_T1) begin
            next_class = OP_CHAR_XCH;
          end else begin
            next_class = OP_CHAR_LOAD;
          end
        end else if (f.addr_type != AT_T1 && f.addr_type != AT_T2) begin
          next_class = OP_CHAR_STOR;
        end
      end
      CODE_CMP: begin
        if (short_fmt) begin
          next_class = OP_TRAP;
        end else if (f.ls && f.addr_type != AT_T1) begin
          next_class = OP_CHAR_CMP;
        end else if (f.addr_type == AT_T1) begin
          next_class = OP_WORD_CMP;
        end else if (!f.ls && !mem_type) begin
          next_class = OP_WORD_CMP;
        end
      end
      CODE_CALL: begin
        if (short_fmt) begin
          if (f.short_reg != 3'h0) begin
            next_class = OP_XREG_WR;
            next_priv  = 1'b1;
          end else if (!f.ls) begin
            next_class = OP_MOVE_FWD;
          end
        end else if (f.ls) begin
          next_class = OP_CALL;
        end else if (f.addr_type == AT_T3) begin
          next_class = OP_GENERAL;
        end
      end
      CODE_XRD: begin
        if (short_fmt) begin
          if (f.short_reg != 3'h0) begin
            next_class = OP_XREG_RD;
            next_priv  = 1'b1;
          end else if (!f.ls) begin
            next_class = OP_MOVE_BWD;
          end
        end
      end
      default: begin
        next_class = OP_TRAP;
      end
    endcase
    // no floating hardware: those words go to the trap flow
    if (!FLOATING_POINT_OPTION &&
        (next_class == OP_FP_LOAD || next_class == OP_FP_STORE ||
         next_class == OP_FP_ARITH)) begin
      next_class = OP_TRAP;
    end
  end

  // ---------------------------------------------------------
  // decoded class outputs, and fields taken straight from the captured word
  // ---------------------------------------------------------
  assign OP_CLASS              = next_class;
  assign TRAP_REQUEST          = (next_class == OP_TRAP);
  assign PRIVILEGED            = next_priv;
  assign OPERATION_CODE_FIELD  = f.opcode;
  assign FIRST_OPERAND_SELECT  = f.first_sel;
  assign SECOND_OPERAND_SELECT = f.second_sel;
  assign SHORT_FORMAT_REGISTER = f.short_reg;
  assign BRANCH_CONDITION_FIELD = f.cond;
  assign ADDRESSING_MODE_FIELD = f.mode;
  assign ADDRESS_TYPE          = f.addr_type;
  // short-format words have no store bit meaning
  assign STORE_TO_MEMORY       = f.fmt && f.ls;
  assign SHIFT_KIND            = mcid_shift_t'(word[SHSEL_HI:SHSEL_LO]);
  assign SHIFT_RIGHT           = word[SHDIR_BIT];

  // ---------------------------------------------------------
  // branch condition decision
  // ---------------------------------------------------------
  // the all-ones pattern overrides the mismatch test
  always_comb begin
    if (f.cond == 3'b111) begin
      BRANCH_TAKEN = 1'b1;
    end else if (!f.cond[2]) begin
      BRANCH_TAKEN = (CONDITION_REGISTER == f.cond[1:0]);
    end else begin
      BRANCH_TAKEN = (CONDITION_REGISTER != f.cond[1:0]);
    end
  end

  // ---------------------------------------------------------
  // checks
  // ---------------------------------------------------------
  format_split_a: assert property (
    @(posedge REF_CLK) disable iff (SRST)
    LOAD_WORD && !INSTR_IN[FMT_BIT] |=> ADDRESS_TYPE == AT_T8
  ) else $error("short layout not typed as short constant");

  first_bank_a: assert property (
    @(posedge REF_CLK) disable iff (SRST)
    LOAD_WORD |=> FIRST_OPERAND_SELECT[3] == $past(INSTR_IN[FIRST_LO])
  ) else $error("first operand bank wrong");

  second_bank_a: assert property (
    @(posedge REF_CLK) disable iff (SRST)
    LOAD_WORD |=> SECOND_OPERAND_SELECT[3] == $past(INSTR_IN[SECOND_LO])
  ) else $error("second operand bank wrong");

  store_route_a: assert property (
    @(posedge REF_CLK) disable iff (SRST)
    LOAD_WORD && INSTR_IN[FMT_BIT] |=>
      STORE_TO_MEMORY == $past(INSTR_IN[LS_BIT])
  ) else $error("store destination wrong");

  branch_always_a: assert property (
    @(posedge REF_CLK) disable iff (SRST)
    BRANCH_CONDITION_FIELD == 3'b111 |-> BRANCH_TAKEN
  ) else $error("unconditional branch not taken");

  branch_match_a: assert property (
    @(posedge REF_CLK) disable iff (SRST)
    BRANCH_CONDITION_FIELD[2] == 1'b0 |->
      BRANCH_TAKEN == (CONDITION_REGISTER == BRANCH_CONDITION_FIELD[1:0])
  ) else $error("match branch decision wrong");

  abs_branch_a: assert property (
    @(posedge REF_CLK) disable iff (SRST)
    LOAD_WORD && INSTR_IN[15:11] == 5'h11 && INSTR_IN[6] &&
      !INSTR_IN[LS_BIT] |=> OP_CLASS == OP_ABS
  ) else $error("memory absolute branch not decoded");

  rel_branch_a: assert property (
    @(posedge REF_CLK) disable iff (SRST)
    LOAD_WORD && INSTR_IN[15:11] == 5'h0b && !INSTR_IN[LS_BIT]
      |=> OP_CLASS == OP_REL_BWD && !TRAP_REQUEST
  ) else $error("backward relative branch not decoded");

  call_decode_a: assert property (
    @(posedge REF_CLK) disable iff (SRST)
    LOAD_WORD && INSTR_IN[15:11] == 5'h1e && INSTR_IN[LS_BIT]
      |=> OP_CLASS == OP_CALL
  ) else $error("call not decoded");

  fp_absent_a: assert property (
    @(posedge REF_CLK) disable iff (SRST)
    !FLOATING_POINT_OPTION && f.fmt && f.opcode == CODE_FPAR
      |-> TRAP_REQUEST
  ) else $error("floating opcode ran without option");

  long_const_a: assert property (
    @(posedge REF_CLK) disable iff (SRST)
    LOAD_WORD && INSTR_IN[FMT_BIT] && INSTR_IN[6:5] == 2'b01 &&
      INSTR_IN[4:1] == 4'h0 |=> ADDRESS_TYPE == AT_T2
  ) else $error("long constant type not decoded");

  norm_store_a: assert property (
    @(posedge REF_CLK) disable iff (SRST)
    !f.fmt && f.opcode == CODE_SHIFT && SHIFT_KIND == SH_NORM && f.ls
      |-> TRAP_REQUEST
  ) else $error("normalize with store bit not trapped");

  branch_differ_a: assert property (
    @(posedge REF_CLK) disable iff (SRST)
    BRANCH_CONDITION_FIELD[2] && BRANCH_CONDITION_FIELD != 3'b111 |->
      BRANCH_TAKEN == (CONDITION_REGISTER != BRANCH_CONDITION_FIELD[1:0])
  ) else $error("mismatch branch decision wrong");

  clear_mem_a: assert property (
    @(posedge REF_CLK) disable iff (SRST)
    LOAD_WORD && INSTR_IN[15:11] == 5'h14 && INSTR_IN[6] &&
      INSTR_IN[LS_BIT] |=> OP_CLASS == OP_CLEAR_MEM
  ) else $error("memory clear not decoded");

  xreg_priv_a: assert property (
    @(posedge REF_CLK) disable iff (SRST)
    OP_CLASS inside {OP_XREG_WR, OP_XREG_RD} |-> PRIVILEGED
  ) else $error("external register access not privileged");

  reset_clear_a: assert property (
    @(posedge REF_CLK)
    SRST |=> OPERATION_CODE_FIELD == 4'h0 && OP_CLASS == OP_GENERAL
  ) else $error("reset did not clear captured word");

endmodule

// >>> design/mcid_pkg.sv
package mcid_pkg;

  // ---------------------------------------------------------
  // field positions in the captured word (vector bit 15 is
  // the word's leading bit)
  // ---------------------------------------------------------
  localparam int FMT_BIT    = 15;
  localparam int CODE_HI    = 14;
  localparam int CODE_LO    = 11;
  localparam int COND_HI    = 10;
  localparam int COND_LO    = 8;
  localparam int FIRST_HI   = 10;
  localparam int FIRST_LO   = 7;
  localparam int MODE_HI    = 6;
  localparam int MODE_LO    = 5;
  localparam int SECOND_HI  = 4;
  localparam int SECOND_LO  = 1;
  localparam int LS_BIT     = 0;
  localparam int SHSEL_HI   = 7;
  localparam int SHSEL_LO   = 6;
  localparam int SHDIR_BIT  = 5;

  // value after reset of the captured word
  localparam logic [15:0] WORD_RESET = 16'h0000;

  // ---------------------------------------------------------
  // operation codes
  // ---------------------------------------------------------
  localparam logic [3:0] CODE_LOAD  = 4'h0;
  localparam logic [3:0] CODE_ABS   = 4'h1;
  localparam logic [3:0] CODE_ADD   = 4'h2;
  localparam logic [3:0] CODE_SUB   = 4'h3;
  localparam logic [3:0] CODE_AND   = 4'h4;
  localparam logic [3:0] CODE_OR    = 4'h5;
  localparam logic [3:0] CODE_XOR   = 4'h6;
  localparam logic [3:0] CODE_SHIFT = 4'h7;
  localparam logic [3:0] CODE_FPLS  = 4'h8;
  localparam logic [3:0] CODE_FPAR  = 4'h9;
  localparam logic [3:0] CODE_FWD   = 4'ha;
  localparam logic [3:0] CODE_BWD   = 4'hb;
  localparam logic [3:0] CODE_CHAR  = 4'hc;
  localparam logic [3:0] CODE_CMP   = 4'hd;
  localparam logic [3:0] CODE_CALL  = 4'he;
  localparam logic [3:0] CODE_XRD   = 4'hf;

  typedef enum logic [3:0] {
    AT_T1 = 4'b0001, AT_T2 = 4'b0010, AT_T3 = 4'b0011,
    AT_T4 = 4'b0100, AT_T5 = 4'b0101, AT_T6 = 4'b0110,
    AT_T7 = 4'b0111, AT_T8 = 4'b1000
  } mcid_addr_t;

  typedef enum logic [1:0] {
    SH_ARITH = 2'b00, SH_LOGIC = 2'b01,
    SH_NORM  = 2'b10, SH_CIRC  = 2'b11
  } mcid_shift_t;

  typedef enum logic [4:0] {
    OP_TRAP      = 5'b00000, OP_GENERAL   = 5'b00001,
    OP_ABS_COND  = 5'b00010, OP_ABS       = 5'b00011,
    OP_REL_FWD   = 5'b00100, OP_REL_BWD   = 5'b00101,
    OP_CALL      = 5'b00110, OP_DADD      = 5'b00111,
    OP_CHAR_XCH  = 5'b01000, OP_CHAR_LOAD = 5'b01001,
    OP_CHAR_STOR = 5'b01010, OP_CHAR_CMP  = 5'b01011,
    OP_WORD_CMP  = 5'b01100, OP_CLEAR_MEM = 5'b01101,
    OP_SHIFT1    = 5'b01110, OP_SHIFT2    = 5'b01111,
    OP_MOVE_FWD  = 5'b10000, OP_MOVE_BWD  = 5'b10001,
    OP_XREG_WR   = 5'b10010, OP_XREG_RD   = 5'b10011,
    OP_FP_LOAD   = 5'b10100, OP_FP_STORE  = 5'b10101,
    OP_FP_ARITH  = 5'b10110, OP_SEG_LOAD  = 5'b10111,
    OP_SEG_STORE = 5'b11000
  } mcid_op_t;

endpackage

// >>> design/mcid_fields_if.sv
interface mcid_fields_if;
  import mcid_pkg::*;
  logic [15:0] word;
  logic        fmt;
  logic [3:0]  opcode;
  logic [2:0]  cond;
  logic [3:0]  first_sel;
  logic [3:0]  second_sel;
  logic [2:0]  short_reg;
  logic [1:0]  mode;
  logic        ls;
  mcid_addr_t  addr_type;

  modport extract (
    input  word,
    output fmt, opcode, cond, first_sel, second_sel,
    output short_reg, mode, ls, addr_type
  );
  modport decode (
    output word,
    input  fmt, opcode, cond, first_sel, second_sel,
    input  short_reg, mode, ls, addr_type
  );
endinterface

// >>> design/mcid_field_extract.sv
module mcid_field_extract
  import mcid_pkg::*;
(
  mcid_fields_if.extract f
);

  // ---------------------------------------------------------
  // plain field slicing
  // ---------------------------------------------------------
  assign f.fmt        = f.word[FMT_BIT];
  assign f.opcode     = f.word[CODE_HI:CODE_LO];
  assign f.cond       = f.word[COND_HI:COND_LO];
  // the bank bit sits last in each field, so it moves to the top
  assign f.first_sel  = {f.word[FIRST_LO], f.word[FIRST_HI:FIRST_LO+1]};
  assign f.second_sel = {f.word[SECOND_LO], f.word[SECOND_HI:SECOND_LO+1]};
  assign f.short_reg  = f.word[COND_HI:COND_LO];
  assign f.mode       = f.word[MODE_HI:MODE_LO];
  assign f.ls         = f.word[LS_BIT];

  // ---------------------------------------------------------
  // addressing type from format, mode and second register
  // ---------------------------------------------------------
  always_comb begin
    logic second_zero;
    second_zero = (f.second_sel == 4'h0);
    if (!f.fmt) begin
      f.addr_type = AT_T8;
    end else begin
      case (f.mode)
        2'b00:   f.addr_type = AT_T1;
        2'b01:   f.addr_type = second_zero ? AT_T2 : AT_T3;
        2'b10:   f.addr_type = second_zero ? AT_T4 : AT_T5;
        2'b11:   f.addr_type = second_zero ? AT_T6 : AT_T7;
        default: f.addr_type = AT_T1;
      endcase
    end
  end

endmodule

// >>> bench/mcid_seq_model.sv
// ---------------------------------------------------------
// sequencer stand-in: condition code and trap watch
// ---------------------------------------------------------
module mcid_seq_model
  import mcid_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       srst,
  input  wire logic       cc_load,
  input  wire logic [1:0] cc_val,
  input  wire mcid_op_t   op_class,
  input  wire logic       trap_request,
  output logic [1:0]      condition_register,
  output logic [15:0]     trap_cycles
);
  timeunit 1ns;
  timeprecision 1ps;

  // condition code moves only on request, as the real flags would
  always_ff @(posedge clk) begin
    if (srst) begin
      condition_register <= 2'h0;
    end else if (cc_load) begin
      condition_register <= cc_val;
    end
  end

  // count cycles spent in the trap class; a hang shows as a long run
  always_ff @(posedge clk) begin
    if (srst) begin
      trap_cycles <= 16'h0000;
    end else if (trap_request && op_class == OP_TRAP) begin
      trap_cycles <= trap_cycles + 16'h0001;
    end
  end
endmodule

// >>> bench/test_minicomputer_instruction_decoder.sv
module test_minicomputer_instruction_decoder;
  import mcid_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin num_errors++; $display("CHECK FAILED %s expected %0h seen %0h", nm, e, g); end end

  // ---------------------------------------------------------
  // signals
  // ---------------------------------------------------------
  logic        ref_clk, srst, load_word, fpo, cc_load;
  logic [15:0] instr_in;
  logic [1:0]  cc_val, cond_reg;
  mcid_op_t    op_class;
  logic        trap_request, privileged, store_mem, branch_taken, shift_right;
  logic [3:0]  opc_f, first_sel, second_sel;
  logic [2:0]  short_reg, cond_f;
  logic [1:0]  mode_f;
  mcid_addr_t  addr_type;
  mcid_shift_t shift_kind;
  logic [15:0] trap_cycles, tc0;
  int          num_errors, n_compared;
  logic [15:0] rw[$];
  mcid_op_t    ro[$];
  logic        ropt[$];

  mcid_decoder dut (
    .REF_CLK(ref_clk), .SRST(srst), .LOAD_WORD(load_word), .INSTR_IN(instr_in),
    .CONDITION_REGISTER(cond_reg), .FLOATING_POINT_OPTION(fpo),
    .OP_CLASS(op_class), .TRAP_REQUEST(trap_request), .PRIVILEGED(privileged),
    .OPERATION_CODE_FIELD(opc_f), .FIRST_OPERAND_SELECT(first_sel),
    .SECOND_OPERAND_SELECT(second_sel), .SHORT_FORMAT_REGISTER(short_reg),
    .BRANCH_CONDITION_FIELD(cond_f), .ADDRESSING_MODE_FIELD(mode_f),
    .ADDRESS_TYPE(addr_type), .STORE_TO_MEMORY(store_mem),
    .BRANCH_TAKEN(branch_taken), .SHIFT_KIND(shift_kind), .SHIFT_RIGHT(shift_right)
  );

  mcid_seq_model seq (
    .clk(ref_clk), .srst(srst), .cc_load(cc_load), .cc_val(cc_val),
    .op_class(op_class), .trap_request(trap_request),
    .condition_register(cond_reg), .trap_cycles(trap_cycles)
  );

  // ---------------------------------------------------------
  // helpers
  // ---------------------------------------------------------
  // long layout: leading bit 1, opcode, first reg, mode, second reg, store bit
  function automatic logic [15:0] L(int o, int fs, int am, int ss, int s);
    return {1'b1, o[3:0], fs[3:0], am[1:0], ss[3:0], s[0]};
  endfunction

  // short layout: register field, then shift selector and direction
  function automatic logic [15:0] S(int o, int sr, int k, int s);
    return {1'b0, o[3:0], sr[2:0], k[2:0], 4'h0, s[0]};
  endfunction

  function automatic mcid_addr_t exp_at(logic [15:0] w);
    logic z;
    z = (w[4:1] == 4'h0);
    if (!w[15]) return AT_T8;
    case (w[6:5])
      2'h0: return AT_T1;
      2'h1: return z ? AT_T2 : AT_T3;
      2'h2: return z ? AT_T4 : AT_T5;
      default: return z ? AT_T6 : AT_T7;
    endcase
  endfunction

  function automatic void r(logic [15:0] w, mcid_op_t op, logic f = 1'b1);
    rw.push_back(w);
    ro.push_back(op);
    ropt.push_back(f);
  endfunction

  // one capture edge, then outputs are read 1 ns after it
  task automatic ld(logic [15:0] w, logic f, logic [1:0] cc);
    @(posedge ref_clk);
    load_word <= 1'b1;
    instr_in  <= w;
    fpo       <= f;
    cc_load   <= 1'b1;
    cc_val    <= cc;
    @(posedge ref_clk);
    load_word <= 1'b0;
    cc_load   <= 1'b0;
    #1;
  endtask

  task automatic chk_row(logic [15:0] w, mcid_op_t op);
    `CHK("op_class", op, op_class);
    `CHK("trap", (op == OP_TRAP), trap_request);
    `CHK("addr_type", exp_at(w), addr_type);
    `CHK("opcode", w[14:11], opc_f);
    `CHK("store", w[15] & w[0], store_mem);
    `CHK("priv", (op inside {OP_XREG_WR, OP_XREG_RD, OP_SEG_LOAD, OP_SEG_STORE}),
         privileged);
    if (w[15]) begin
      `CHK("first_bank", w[7], first_sel[3]);
      `CHK("second_bank", w[1], second_sel[3]);
      `CHK("mode", w[6:5], mode_f);
    end else begin
      `CHK("short_reg", w[10:8], short_reg);
      if (op inside {OP_SHIFT1, OP_SHIFT2}) begin
        `CHK("shift_kind", w[7:6], shift_kind);
        `CHK("shift_dir", w[5], shift_right);
      end
    end
  endtask

  task automatic end_sim();
    if (num_errors == 0 && n_compared > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // ---------------------------------------------------------
  // clock, reset, watchdog
  // ---------------------------------------------------------
  // 250 MHz reference
  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end

  // the run needs under two hundred cycles; over twenty-five times that means a hang
  initial begin
    repeat (5000) @(posedge ref_clk);
    num_errors++;
    end_sim();
  end

  // main sequence
  initial begin
    num_errors = 0; n_compared = 0;
    srst = 1'b1; load_word = 1'b0; instr_in = 16'h0000; fpo = 1'b1;
    cc_load = 1'b0; cc_val = 2'h0;
    repeat (6) @(posedge ref_clk);
    srst <= 1'b0;
    @(posedge ref_clk);
    #1;
    `CHK("rst_class", OP_GENERAL, op_class);
    `CHK("rst_type", AT_T8, addr_type);
    `CHK("rst_branch", 1'b1, branch_taken);
    // decode table: one row per encoding corner
    r(S(1,0,0,0), OP_ABS_COND); r(L(1,0,0,0,0), OP_ABS_COND);
    r(L(1,0,1,0,0), OP_ABS_COND); r(L(1,0,1,3,0), OP_ABS_COND);
    r(L(1,0,2,0,0), OP_ABS); r(L(1,0,3,5,0), OP_ABS);
    r(S(10,1,0,0), OP_REL_FWD); r(S(11,2,0,0), OP_REL_BWD);
    r(L(14,1,1,0,1), OP_CALL); r(L(14,1,0,2,1), OP_CALL);
    r(L(14,1,1,2,1), OP_CALL); r(L(14,1,2,4,1), OP_CALL);
    r(L(10,2,1,0,0), OP_DADD); r(L(10,2,0,3,0), OP_DADD);
    r(L(10,2,3,0,0), OP_DADD);
    r(L(12,1,0,1,0), OP_CHAR_XCH); r(L(12,1,1,0,0), OP_CHAR_LOAD);
    r(L(12,1,1,9,0), OP_CHAR_LOAD); r(L(12,1,2,9,0), OP_CHAR_LOAD);
    r(L(12,1,1,2,1), OP_CHAR_STOR); r(L(12,1,3,0,1), OP_CHAR_STOR);
    r(L(13,1,1,0,1), OP_CHAR_CMP); r(L(13,1,1,4,1), OP_CHAR_CMP);
    r(L(13,1,3,4,1), OP_CHAR_CMP);
    r(L(13,1,1,0,0), OP_WORD_CMP); r(L(13,1,0,2,1), OP_WORD_CMP);
    r(L(13,1,1,4,0), OP_WORD_CMP);
    r(L(4,1,1,2,1), OP_CLEAR_MEM); r(L(4,1,2,0,1), OP_CLEAR_MEM);
    r(S(7,3,0,0), OP_SHIFT1); r(S(7,3,3,1), OP_SHIFT1);
    r(S(7,3,6,0), OP_SHIFT1); r(S(7,3,4,0), OP_SHIFT1);
    r(S(7,3,5,1), OP_TRAP);
    r(S(7,0,1,0), OP_SHIFT2); r(S(7,0,7,1), OP_SHIFT2);
    r(S(7,0,4,0), OP_SHIFT2); r(S(7,0,2,1), OP_SHIFT2);
    r(S(14,0,0,0), OP_MOVE_FWD); r(S(15,0,0,0), OP_MOVE_BWD);
    r(S(14,5,0,0), OP_XREG_WR); r(S(15,7,0,1), OP_XREG_RD);
    r(L(8,1,1,3,0), OP_FP_LOAD); r(L(8,1,2,0,1), OP_FP_STORE);
    r(L(8,1,1,3,0), OP_TRAP, 1'b0); r(L(8,1,2,0,1), OP_TRAP, 1'b0);
    r(L(9,1,2,0,0), OP_FP_ARITH); r(L(9,1,2,0,0), OP_TRAP, 1'b0);
    r(L(7,0,1,3,0), OP_SEG_LOAD); r(L(7,0,3,1,1), OP_SEG_STORE);
    r(L(15,1,0,0,0), OP_TRAP); r(S(10,1,0,1), OP_TRAP);
    r(L(2,1,0,8,0), OP_GENERAL); r(L(2,8,2,0,1), OP_GENERAL);
    foreach (rw[i]) begin
      ld(rw[i], ropt[i], 2'h0);
      chk_row(rw[i], ro[i]);
    end
    // every condition field against every condition code
    for (int c = 0; c < 8; c++) begin
      for (int k = 0; k < 4; k++) begin
        ld(S(1,c,0,0), 1'b1, k[1:0]);
        `CHK("cond_field", c[2:0], cond_f);
        `CHK("branch", (c == 7) ? 1'b1 : (c[2] ? (k[1:0] != c[1:0]) :
             (k[1:0] == c[1:0])), branch_taken);
      end
    end
    // word must hold while the strobe is low
    ld(L(14,1,1,0,1), 1'b1, 2'h0);
    instr_in <= L(15,1,0,0,0);
    @(posedge ref_clk);
    #1;
    `CHK("hold", OP_CALL, op_class);
    // option input acts in the same cycle, no reload
    ld(L(8,1,1,3,0), 1'b1, 2'h0);
    tc0 = trap_cycles;
    fpo <= 1'b0;
    #1;
    `CHK("fp_drop", OP_TRAP, op_class);
    // reset wins over a capture strobe in mid-run
    @(posedge ref_clk);
    srst      <= 1'b1;
    load_word <= 1'b1;
    instr_in  <= L(15,1,0,0,0);
    #1;
    `CHK("trap_count", tc0 + 16'h0001, trap_cycles);
    @(posedge ref_clk);
    srst      <= 1'b0;
    load_word <= 1'b0;
    #1;
    `CHK("rst_wins", OP_GENERAL, op_class);
    `CHK("trap_clear", 16'h0000, trap_cycles);
    end_sim();
  end
endmodule
